// *** rtl/pci_params.svh ***
// Contract
// - Rising-edge enable set: each low-to-high pin transition raises a change request.
// - Falling-edge enable set: each high-to-low pin transition raises a change request.
// - Both enables set: one pulse yields two separate change requests; here the second edge is dropped while status bit 0 is set.
// - Detect only with enable-one bit 3, module enable bit 15, change flag clear.
// - Edge detection keeps working in sleep, independent of processor clock gating.
// - A detected edge sets that pin's individual change flag.
// - Pin change flag stays set until software writes zero; hardware never clears it.
// - Port summary flag is set while any pin flag of that port is set.
// - Port summary flag clears only when all sixteen pin flags are clear.
// - Edge during read-modify-write clear leaves the flag set afterwards.
// - Each pin has its own weak pull-up and weak pull-down enable bit.
// - Configuration register bit 15 enables the module, resets zero, bits 14-0 read zero.
// - Summary register is read-only; bits 0-6 are ports A-G, bits 15-7 read zero.
`ifndef PCI_PARAMS_SVH
`define PCI_PARAMS_SVH
`default_nettype none

// =============================================================================
// Register word addresses.
`define PCI_ADDR_CFG      8'h00
`define PCI_ADDR_SUMMARY  8'h01
`define PCI_ADDR_IEN1     8'h02
`define PCI_ADDR_ISTAT    8'h03
`define PCI_ADDR_IMASK    8'h04

// =============================================================================
// Per-port window: address bits [7:6] select it, [5:3] the port, [2:0] the field.
`define PCI_PORT_WIN      2'h1
`define PCI_FLD_RISE      3'h0
`define PCI_FLD_FALL      3'h1
`define PCI_FLD_FLAG      3'h2
`define PCI_FLD_PULLUP    3'h3
`define PCI_FLD_PULLDN    3'h4

// =============================================================================
// Field positions and reset values.
`define PCI_CFG_EN_BIT    15
`define PCI_IEN1_BIT      3
`define PCI_IST_CHANGE    0
`define PCI_IST_IDLE      1
`define PCI_IST_W         2
`define PCI_RST_WORD      16'h0000
`define PCI_ALL_ONES      16'hFFFF

`default_nettype wire
`endif

// *** rtl/pci_pkg.sv ***
`include "pci_params.svh"
`default_nettype none

// =============================================================================
// Shared types of the pin change unit.
package pci_pkg;

	// One register word on the software port.
	typedef logic [15:0] pci_word_t;

	// Field selector inside one port's register window.
	typedef enum logic [2:0] {
		PCI_F_RISE   = `PCI_FLD_RISE,
		PCI_F_FALL   = `PCI_FLD_FALL,
		PCI_F_FLAG   = `PCI_FLD_FLAG,
		PCI_F_PULLUP = `PCI_FLD_PULLUP,
		PCI_F_PULLDN = `PCI_FLD_PULLDN
	} pci_field_t;

endpackage

`default_nettype wire

// *** rtl/pci_edge_if.sv ***
`default_nettype none

// =============================================================================
// Edge events of one port, from the detector to the flag logic.
interface pci_edge_if #(
	parameter int W = 16
);
	logic [W-1:0] rise;
	logic [W-1:0] fall;

	modport det  (output rise, output fall);
	modport core (input  rise, input  fall);
endinterface

`default_nettype wire

// *** rtl/pci_edge_det.sv ***
`default_nettype none

// =============================================================================
// Per-port edge detector: two-stage synchroniser, then compare with last level.
module pci_edge_det #(
	parameter int W = 16
) (
	// Clock and synchronised reset.
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// Asynchronous pin levels.
	input  wire logic [W-1:0] pin_i,
	// Edge events.
	pci_edge_if.det           edges
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] sync_reg;
	logic [W-1:0] sync_next;
	logic [W-1:0] prev_reg;
	logic [W-1:0] prev_next;

	// The first stage feeds only the second; edges are judged on stable levels.
	always_comb begin
		meta_next = pin_i;
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	// This runs on the always-on clock, so it keeps catching edges in sleep.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	// Both directions are reported independently, so a pulse gives two events.
	assign edges.rise = sync_reg & ~prev_reg;
	assign edges.fall = ~sync_reg & prev_reg;

endmodule

`default_nettype wire

// *** rtl/pci_top.sv ***
// Decided for this implementation: strobed register access and the register addresses.
`include "pci_params.svh"
`default_nettype none

// =============================================================================
// Pin change interrupt unit: edge enables, sticky pin flags, port summaries,
// weak pull controls and the change request towards the processor.
module pci_top #(
	parameter int NPORT = 7,
	parameter int NPIN  = 16
) (
	// Clock and reset.
	input  wire logic                        clk_i,
	input  wire logic                        rstn_i,
	// Register port.
	input  wire logic [7:0]                  addr_i,
	input  wire logic [15:0]                 wdata_i,
	input  wire logic                        wr_i,
	input  wire logic                        rd_i,
	output logic      [15:0]                 rdata_o,
	// Input pins, one row per port.
	input  wire logic [NPORT-1:0][NPIN-1:0]  pin_i,
	// Weak pull controls, one row per port.
	output logic      [NPORT-1:0][NPIN-1:0]  pullup_en_o,
	output logic      [NPORT-1:0][NPIN-1:0]  pulldown_en_o,
	// Towards the processor interrupt logic.
	output logic                             chg_req_o,
	output logic                             irq_o
);

	// =========================================================================
	// Address decoding helpers.

	// True when the address falls inside an implemented port window.
	function automatic logic is_port_addr(input logic [7:0] a);
		is_port_addr = (a[7:6] == `PCI_PORT_WIN) && (int'(a[5:3]) < NPORT);
	endfunction

	// Port number of a window address.
	function automatic logic [2:0] port_of(input logic [7:0] a);
		port_of = a[5:3];
	endfunction

	// Field selector of a window address.
	function automatic pci_pkg::pci_field_t field_of(input logic [7:0] a);
		field_of = pci_pkg::pci_field_t'(a[2:0]);
	endfunction

	// =========================================================================
	// Reset release.

	logic [1:0] rst_sync_reg;
	logic       rst_n;

	// Reset asserts at once but releases only after two clean clock edges.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_reg[1];

	// =========================================================================
	// Edge detectors.

	logic [NPORT-1:0][NPIN-1:0] rise_ev;
	logic [NPORT-1:0][NPIN-1:0] fall_ev;

	pci_edge_if #(.W(NPIN)) eif [NPORT] ();

	// One detector per port; the event lines are flattened for the flag logic.
	for (genvar g = 0; g < NPORT; g++) begin : g_port
		pci_edge_det #(
			.W(NPIN)
		) u_det (
			.clk_i  (clk_i),
			.rst_n_i(rst_n),
			.pin_i  (pin_i[g]),
			.edges  (eif[g])
		);
		assign rise_ev[g] = eif[g].rise;
		assign fall_ev[g] = eif[g].fall;
	end

	// =========================================================================
	// Register state.

	logic [NPORT-1:0][NPIN-1:0] rise_en_reg;
	logic [NPORT-1:0][NPIN-1:0] rise_en_next;
	logic [NPORT-1:0][NPIN-1:0] fall_en_reg;
	logic [NPORT-1:0][NPIN-1:0] fall_en_next;
	logic [NPORT-1:0][NPIN-1:0] flag_reg;
	logic [NPORT-1:0][NPIN-1:0] flag_next;
	logic [NPORT-1:0][NPIN-1:0] pullup_reg;
	logic [NPORT-1:0][NPIN-1:0] pullup_next;
	logic [NPORT-1:0][NPIN-1:0] pulldn_reg;
	logic [NPORT-1:0][NPIN-1:0] pulldn_next;
	logic                       mod_en_reg;
	logic                       mod_en_next;
	logic                       ien1_reg;
	logic                       ien1_next;
	logic [`PCI_IST_W-1:0]      istat_reg;
	logic [`PCI_IST_W-1:0]      istat_next;
	logic [`PCI_IST_W-1:0]      imask_reg;
	logic [`PCI_IST_W-1:0]      imask_next;
	logic                       chg_req_reg;
	logic                       chg_req_next;
	pci_pkg::pci_word_t         rdata_reg;
	pci_pkg::pci_word_t         rdata_next;

	// =========================================================================
	// Derived status.

	logic [NPORT-1:0] summary;
	logic [NPORT-1:0] summary_next;
	logic             detect_on;
	logic             any_hit;

	// A port summary simply mirrors its flags: set by any, clear only by none.
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			summary[p]      = |flag_reg[p];
			summary_next[p] = |flag_next[p];
		end
	end

	// Detection needs both enables and a clear change flag; otherwise edges
	// are tracked by the detectors but not recorded.
	assign detect_on = ien1_reg & mod_en_reg & ~istat_reg[`PCI_IST_CHANGE];

	// =========================================================================
	// Next values for the configuration and per-port registers.

	always_comb begin
		logic          win_wr;
		logic [NPIN-1:0] hit;
		win_wr       = wr_i && is_port_addr(addr_i);
		hit          = '0;
		rise_en_next = rise_en_reg;
		fall_en_next = fall_en_reg;
		pullup_next  = pullup_reg;
		pulldn_next  = pulldn_reg;
		flag_next    = flag_reg;
		mod_en_next  = mod_en_reg;
		ien1_next    = ien1_reg;
		imask_next   = imask_reg;
		any_hit      = 1'b0;

		if (wr_i && addr_i == `PCI_ADDR_CFG) begin
			mod_en_next = wdata_i[`PCI_CFG_EN_BIT];
		end
		if (wr_i && addr_i == `PCI_ADDR_IEN1) begin
			ien1_next = wdata_i[`PCI_IEN1_BIT];
		end
		if (wr_i && addr_i == `PCI_ADDR_IMASK) begin
			imask_next = wdata_i[`PCI_IST_W-1:0];
		end

		for (int p = 0; p < NPORT; p++) begin
			// Writes can only clear flags; a one written leaves the flag alone,
			// which is what makes the invert-and-AND clear safe.
			if (win_wr && port_of(addr_i) == 3'(p)) begin
				case (field_of(addr_i))
					pci_pkg::PCI_F_RISE: begin
						rise_en_next[p] = wdata_i[NPIN-1:0];
					end
					pci_pkg::PCI_F_FALL: begin
						fall_en_next[p] = wdata_i[NPIN-1:0];
					end
					pci_pkg::PCI_F_FLAG: begin
						flag_next[p] = flag_reg[p] & wdata_i[NPIN-1:0];
					end
					pci_pkg::PCI_F_PULLUP: begin
						pullup_next[p] = wdata_i[NPIN-1:0];
					end
					pci_pkg::PCI_F_PULLDN: begin
						pulldn_next[p] = wdata_i[NPIN-1:0];
					end
					default: begin
					end
				endcase
			end
			// Enabled edges in either direction; both may fire for one pulse.
			hit = (rise_ev[p] & rise_en_reg[p]) | (fall_ev[p] & fall_en_reg[p]);
			if (!detect_on) begin
				hit = '0;
			end
			// The set is applied after the clear so a racing edge survives.
			flag_next[p] = flag_next[p] | hit;
			any_hit      = any_hit | (|hit);
		end
	end

	// =========================================================================
	// Next values for interrupt status, request and read data.

	always_comb begin
		istat_next = istat_reg;
		// Reading the status clears it; an event in the same cycle still lands.
		if (rd_i && addr_i == `PCI_ADDR_ISTAT) begin
			istat_next = '0;
		end
		if (any_hit) begin
			istat_next[`PCI_IST_CHANGE] = 1'b1;
		end
		if ((|summary) && !(|summary_next)) begin
			istat_next[`PCI_IST_IDLE] = 1'b1;
		end

		// Request tracks pending flags, and drops as soon as the module is off.
		chg_req_next = (|summary_next) & mod_en_next;

		rdata_next = `PCI_RST_WORD;
		if (rd_i) begin
			if (is_port_addr(addr_i)) begin
				case (field_of(addr_i))
					pci_pkg::PCI_F_RISE:   rdata_next = 16'(rise_en_reg[port_of(addr_i)]);
					pci_pkg::PCI_F_FALL:   rdata_next = 16'(fall_en_reg[port_of(addr_i)]);
					pci_pkg::PCI_F_FLAG:   rdata_next = 16'(flag_reg[port_of(addr_i)]);
					pci_pkg::PCI_F_PULLUP: rdata_next = 16'(pullup_reg[port_of(addr_i)]);
					pci_pkg::PCI_F_PULLDN: rdata_next = 16'(pulldn_reg[port_of(addr_i)]);
					default:               rdata_next = `PCI_RST_WORD;
				endcase
			end else begin
				case (addr_i)
					`PCI_ADDR_CFG: begin
						rdata_next[`PCI_CFG_EN_BIT] = mod_en_reg;
					end
					`PCI_ADDR_SUMMARY: begin
						rdata_next = 16'(summary);
					end
					`PCI_ADDR_IEN1: begin
						rdata_next[`PCI_IEN1_BIT] = ien1_reg;
					end
					`PCI_ADDR_ISTAT: begin
						rdata_next = 16'(istat_reg);
					end
					`PCI_ADDR_IMASK: begin
						rdata_next = 16'(imask_reg);
					end
					default: begin
						rdata_next = `PCI_RST_WORD;
					end
				endcase
			end
		end
	end

	// =========================================================================
	// Register update.

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rise_en_reg <= '0;
			fall_en_reg <= '0;
			flag_reg    <= '0;
			pullup_reg  <= '0;
			pulldn_reg  <= '0;
			mod_en_reg  <= 1'b0;
			ien1_reg    <= 1'b0;
			istat_reg   <= '0;
			imask_reg   <= '0;
			chg_req_reg <= 1'b0;
			rdata_reg   <= `PCI_RST_WORD;
		end else begin
			rise_en_reg <= rise_en_next;
			fall_en_reg <= fall_en_next;
			flag_reg    <= flag_next;
			pullup_reg  <= pullup_next;
			pulldn_reg  <= pulldn_next;
			mod_en_reg  <= mod_en_next;
			ien1_reg    <= ien1_next;
			istat_reg   <= istat_next;
			imask_reg   <= imask_next;
			chg_req_reg <= chg_req_next;
			rdata_reg   <= rdata_next;
		end
	end

	// =========================================================================
	// Outputs.

	// Pull enables go straight from their registers to the pad cells.
	assign pullup_en_o   = pullup_reg;
	assign pulldown_en_o = pulldn_reg;
	assign chg_req_o     = chg_req_reg;
	assign rdata_o       = rdata_reg;

	// Level interrupt: high while any unmasked status bit stays set.
	assign irq_o = |(istat_reg & imask_reg);

endmodule

`default_nettype wire

// *** bench/pci_pin_model.sv ***
`default_nettype none

// =============================================================================
// Far side: drives the pins and lets a released pin settle to its weak pull.
module pci_pin_model (
	// Clock for the pattern on released lines.
	input  wire logic             clk_i,
	// Wanted levels, drive enables and the unit's pull controls.
	input  wire logic [6:0][15:0] lvl_i,
	input  wire logic [6:0][15:0] drv_i,
	input  wire logic [6:0][15:0] pu_i,
	input  wire logic [6:0][15:0] pd_i,
	// Resolved pin levels.
	output logic      [6:0][15:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [6:0][15:0] flt = '0;

	// A line nobody holds wanders, so a stale level never passes for a driven one.
	always @(posedge clk_i) begin
		flt <= ~flt;
	end

	// Driven lines follow the wanted level; released ones follow the pull.
	assign pin_o = (drv_i & lvl_i) | (~drv_i & (pu_i | (~pd_i & flt)));
endmodule

`default_nettype wire

// *** bench/pci_top_assertions.sv ***
`include "pci_params.svh"
`default_nettype none

// =============================================================================
// Port-level checks of the pin change unit.
module pci_top_assertions #(
	parameter int NPORT = 7,
	parameter int NPIN  = 16
) (
	input wire logic                       clk_i,
	input wire logic                       rstn_i,
	input wire logic [7:0]                 addr_i,
	input wire logic [15:0]                wdata_i,
	input wire logic                       wr_i,
	input wire logic                       rd_i,
	input wire logic [15:0]                rdata_o,
	input wire logic [NPORT-1:0][NPIN-1:0] pin_i,
	input wire logic [NPORT-1:0][NPIN-1:0] pullup_en_o,
	input wire logic [NPORT-1:0][NPIN-1:0] pulldown_en_o,
	input wire logic                       chg_req_o,
	input wire logic                       irq_o
);
	logic        en_q;
	logic [15:0] msk_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	// Shadow enable and mask words, so the checks need no internal probes.
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			en_q  <= 1'b0;
			msk_q <= 16'h0000;
		end else if (wr_i && addr_i == `PCI_ADDR_CFG) begin
			en_q <= wdata_i[`PCI_CFG_EN_BIT];
		end else if (wr_i && addr_i == `PCI_ADDR_IMASK) begin
			msk_q <= wdata_i;
		end
	end

	// Read data and register views.
	a_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
		else $error("read data not zero outside its slot");
	a_sum_upper: assert property (rd_i && addr_i == `PCI_ADDR_SUMMARY |=> rdata_o[15:7] == 9'h000)
		else $error("summary upper bits not zero");
	a_cfg_view: assert property (rd_i && addr_i == `PCI_ADDR_CFG |=> rdata_o == {en_q, 15'h0000})
		else $error("config read differs from written enable");

	// Change request follows flags and the module enable.
	a_req_gated: assert property (!en_q [*2] |-> !chg_req_o)
		else $error("change request while module disabled");
	a_req_cause: assert property ($rose(chg_req_o) |-> $past(pin_i, 3) != $past(pin_i, 4) || !$past(en_q, 2))
		else $error("change request rose without a pin edge");
	a_req_sticky: assert property ($fell(chg_req_o) |-> $past(wr_i) || $past(wr_i, 2))
		else $error("change request fell without a write");

	// Interrupt and pull outputs.
	a_irq_masked: assert property (irq_o |-> msk_q != 16'h0000)
		else $error("interrupt with all causes masked");
	a_pull_write: assert property (!$stable(pullup_en_o) || !$stable(pulldown_en_o) |-> $past(wr_i))
		else $error("pull control changed without a write");
endmodule

bind pci_top pci_top_assertions #(.NPORT(NPORT), .NPIN(NPIN)) u_chk (.clk_i, .rstn_i, .addr_i,
	.wdata_i, .wr_i, .rd_i, .rdata_o, .pin_i, .pullup_en_o, .pulldown_en_o, .chg_req_o, .irq_o);

`default_nettype wire

// *** bench/pci_top_tb.sv ***
`include "pci_params.svh"
`default_nettype none

// =============================================================================
// Self-checking bench for the pin change unit.
module pci_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic             clk_i;
	logic             rstn_i;
	logic             wr_i;
	logic             rd_i;
	logic             chg;
	logic             irq;
	logic [7:0]       addr_i;
	logic [15:0]      wdata_i;
	logic [15:0]      rdata_o;
	logic [6:0][15:0] lvl;
	logic [6:0][15:0] drv;
	logic [6:0][15:0] pin;
	logic [6:0][15:0] pu;
	logic [6:0][15:0] pd;
	int               error_cnt;
	int               n_compared;

	pci_pin_model PM (.clk_i, .lvl_i(lvl), .drv_i(drv), .pu_i(pu), .pd_i(pd), .pin_o(pin));
	pci_top DUT (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .pin_i(pin),
		.pullup_en_o(pu), .pulldown_en_o(pd), .chg_req_o(chg), .irq_o(irq));

	// Free-running clock.
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// =========================================================================
	// Access and compare helpers.
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
		end
	endtask

	// One idle edge after the strobe, so a following write never re-drives it in one step.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i    <= 1'b0;
		@(posedge clk_i);
	endtask

	// Read data stand only in the cycle after the strobe, so sample mid-cycle there.
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		@(negedge clk_i);
		chk(rdata_o, e);
		@(posedge clk_i);
	endtask

	// Compare the request and interrupt lines where they are settled.
	task automatic lines(input logic [1:0] e);
		@(negedge clk_i);
		chk({14'h0000, chg, irq}, {14'h0000, e});
		@(posedge clk_i);
	endtask

	// A pin change is recorded two edges after it is first sampled.
	task automatic pin_set(input int p, input int b, input logic v);
		lvl[p][b] <= v;
		repeat (4) @(posedge clk_i);
	endtask

	function automatic logic [7:0] pa(input int p, input logic [2:0] f);
		return {`PCI_PORT_WIN, 3'(p), f};
	endfunction

	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog: the sequence needs well under a thousand cycles.
	initial begin
		#50000;
		error_cnt++;
		close_out();
	end

	// =========================================================================
	// Test sequence.
	initial begin
		rstn_i = 1'b0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 16'h0000;
		lvl = '0;
		drv = '1;
		error_cnt = 0;
		n_compared = 0;
		repeat (3) @(posedge clk_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		// Reset values, read-only and unmapped places.
		rd(`PCI_ADDR_CFG, 16'h0000);
		wr(`PCI_ADDR_CFG, `PCI_ALL_ONES);
		rd(`PCI_ADDR_CFG, 16'h8000);
		wr(`PCI_ADDR_SUMMARY, `PCI_ALL_ONES);
		rd(`PCI_ADDR_SUMMARY, 16'h0000);
		wr(8'h05, `PCI_ALL_ONES);
		rd(8'h05, 16'h0000);
		// Rising edge on port B pin 2 sets flag, summary and status.
		wr(`PCI_ADDR_IEN1, 16'h0008);
		wr(`PCI_ADDR_IMASK, 16'h0001);
		wr(pa(1, `PCI_FLD_RISE), 16'h0004);
		pin_set(1, 2, 1'b1);
		rd(pa(1, `PCI_FLD_FLAG), 16'h0004);
		rd(`PCI_ADDR_SUMMARY, 16'h0002);
		lines(2'b11);
		rd(`PCI_ADDR_ISTAT, 16'h0001);
		rd(`PCI_ADDR_ISTAT, 16'h0000);
		lines(2'b10);
		// Falling edge counts only once its enable is set; then both directions count.
		pin_set(1, 2, 1'b0);
		rd(`PCI_ADDR_ISTAT, 16'h0000);
		wr(pa(1, `PCI_FLD_FALL), 16'h0004);
		pin_set(1, 2, 1'b1);
		rd(`PCI_ADDR_ISTAT, 16'h0001);
		pin_set(1, 2, 1'b0);
		rd(`PCI_ADDR_ISTAT, 16'h0001);
		rd(pa(1, `PCI_FLD_FLAG), 16'h0004);
		// Second pin, then clear one flag and the rest by inverting against all ones.
		wr(pa(1, `PCI_FLD_RISE), 16'h0204);
		pin_set(1, 9, 1'b1);
		rd(`PCI_ADDR_ISTAT, 16'h0001);
		wr(pa(1, `PCI_FLD_FLAG), 16'hFDFF);
		rd(pa(1, `PCI_FLD_FLAG), 16'h0004);
		rd(`PCI_ADDR_SUMMARY, 16'h0002);
		wr(`PCI_ADDR_IMASK, 16'h0000);
		wr(pa(1, `PCI_FLD_FLAG), 16'h0004 ^ `PCI_ALL_ONES);
		wr(`PCI_ADDR_IMASK, 16'h0001);
		rd(pa(1, `PCI_FLD_FLAG), 16'h0000);
		rd(`PCI_ADDR_SUMMARY, 16'h0000);
		lines(2'b00);
		// An edge landing on the clearing write keeps its flag.
		lvl[1][2] <= 1'b1;
		repeat (2) @(posedge clk_i);
		wr(pa(1, `PCI_FLD_FLAG), 16'h0000);
		rd(pa(1, `PCI_FLD_FLAG), 16'h0004);
		// Status bit 1 still records that all flags went clear earlier.
		rd(`PCI_ADDR_ISTAT, 16'h0003);
		wr(pa(1, `PCI_FLD_FLAG), 16'h0000);
		// No detection with the global enable or module enable off, or the status flag set.
		wr(`PCI_ADDR_IEN1, 16'h0000);
		pin_set(1, 2, 1'b0);
		rd(pa(1, `PCI_FLD_FLAG), 16'h0000);
		wr(`PCI_ADDR_IEN1, 16'h0008);
		wr(`PCI_ADDR_CFG, 16'h0000);
		pin_set(1, 2, 1'b1);
		rd(pa(1, `PCI_FLD_FLAG), 16'h0000);
		wr(`PCI_ADDR_CFG, 16'h8000);
		pin_set(1, 2, 1'b0);
		wr(pa(1, `PCI_FLD_FLAG), 16'hFFFB);
		pin_set(1, 2, 1'b1);
		rd(pa(1, `PCI_FLD_FLAG), 16'h0000);
		wr(`PCI_ADDR_IMASK, 16'h0000);
		lines(2'b00);
		rd(`PCI_ADDR_ISTAT, 16'h0003);
		// Weak pull controls; both pulls on port 3 make its released level exact.
		wr(pa(3, `PCI_FLD_PULLUP), 16'hA5A5);
		wr(pa(3, `PCI_FLD_PULLDN), 16'h5A5A);
		wr(pa(6, `PCI_FLD_PULLDN), 16'h5A5A);
		drv[3] <= 16'h0000;
		rd(pa(3, `PCI_FLD_PULLUP), 16'hA5A5);
		rd(pa(6, `PCI_FLD_PULLDN), 16'h5A5A);
		chk(pu[3], 16'hA5A5);
		chk(pd[6] | pu[6], 16'h5A5A);
		chk(pin[3], 16'hA5A5);
		close_out();
	end
endmodule

`default_nettype wire
